/* File: rtl/rpc_top.sv */
`timescale 1ns/1ns
`include "rpc_params.svh"

module rpc_top
	import rpc_pkg::*;
#(
	parameter int MS_CYCLES = `RPC_CYC_PER_MS
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// nonvolatile word as stored in the cells
	input  wire logic [23:0] NV_WORD,
	// ahb-lite slave
	input  wire logic        HSEL,
	input  wire logic [11:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// decoded configuration and internal reset
	output logic             PWM_PIN_TRISTATE,
	output logic             PWM_PIN_DRIVE,
	output logic             HIGH_SIDE_ACTIVE_HIGH,
	output logic             LOW_SIDE_ACTIVE_HIGH,
	output logic             BROWNOUT_ENABLE,
	output logic      [1:0]  BROWNOUT_LEVEL_SELECT,
	output logic             INT_RESET
);
	localparam logic [31:0] PUD_LONG  = 32'(`RPC_PUD_MS_LONG * MS_CYCLES);
	localparam logic [31:0] PUD_MID   = 32'(`RPC_PUD_MS_MID * MS_CYCLES);
	localparam logic [31:0] PUD_SHORT = 32'(`RPC_PUD_MS_SHORT * MS_CYCLES);

	function automatic logic [31:0] pud_cycles(input logic [1:0] code);
		unique case (code)
			2'b11: pud_cycles = PUD_LONG;
			2'b10: pud_cycles = PUD_MID;
			2'b01: pud_cycles = PUD_SHORT;
			2'b00: pud_cycles = 32'h0;
		endcase
	endfunction

	function automatic rpc_cfg_t cfg_fields(input logic [23:0] w);
		cfg_fields.pwm_pin_reset_mode    = w[`RPC_BIT_PIN_MODE];
		cfg_fields.high_side_polarity    = w[`RPC_BIT_HS_POL];
		cfg_fields.low_side_polarity     = w[`RPC_BIT_LS_POL];
		cfg_fields.brownout_enable       = w[`RPC_BIT_BOR_EN];
		cfg_fields.brownout_level_select = w[`RPC_BIT_BLVL_HI:`RPC_BIT_BLVL_LO];
		cfg_fields.powerup_delay_select  = w[`RPC_BIT_PUD_HI:`RPC_BIT_PUD_LO];
	endfunction

	// sequencer and latched word
	rpc_state_t  state_q, state_d;
	logic [23:0] word_q, word_d;
	logic        ireset_q, ireset_d;
	logic        tmr_load, tmr_done;
	rpc_cfg_t    cfg;

	assign cfg = cfg_fields(word_q);

	always_comb begin
		state_d  = state_q;
		word_d   = word_q;
		ireset_d = ireset_q;
		tmr_load = 1'b0;
		unique case (state_q)
			RPC_ST_LOAD: begin
				// erased cells read one, masked to implemented bits
				word_d   = NV_WORD & `RPC_CFG_MASK;
				tmr_load = 1'b1;
				state_d  = RPC_ST_WAIT;
			end
			RPC_ST_WAIT: begin
				if (tmr_done) begin
					ireset_d = 1'b0;
					state_d  = RPC_ST_RUN;
				end
			end
			RPC_ST_RUN: begin
				ireset_d = 1'b0;
			end
			default: begin
				state_d  = RPC_ST_LOAD;
				ireset_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_q  <= RPC_ST_LOAD;
			word_q   <= `RPC_CFG_ERASED & `RPC_CFG_MASK;
			ireset_q <= 1'b1;
		end else begin
			state_q  <= state_d;
			word_q   <= word_d;
			ireset_q <= ireset_d;
		end
	end

	rpc_pud_timer #(.CNT_W(32)) u_pud (
		.clk      (CLK),
		.rst      (RST),
		.load     (tmr_load),
		.load_val (pud_cycles(word_d[`RPC_BIT_PUD_HI:`RPC_BIT_PUD_LO])),
		.done     (tmr_done)
	);

	// decoded outputs, registered
	logic       tri_q, tri_d, drv_q, drv_d, hs_q, hs_d, ls_q, ls_d, bor_q, bor_d;
	logic [1:0] brownout_level_select_q, brownout_level_select_d;

	always_comb begin
		tri_d  = cfg.pwm_pin_reset_mode;
		drv_d  = !cfg.pwm_pin_reset_mode;
		hs_d   = cfg.high_side_polarity;
		ls_d   = cfg.low_side_polarity;
		bor_d  = cfg.brownout_enable;
		brownout_level_select_d = cfg.brownout_level_select;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tri_q  <= 1'b1;
			drv_q  <= 1'b0;
			hs_q   <= 1'b1;
			ls_q   <= 1'b1;
			bor_q  <= 1'b1;
			brownout_level_select_q <= 2'h3;
		end else begin
			tri_q  <= tri_d;
			drv_q  <= drv_d;
			hs_q   <= hs_d;
			ls_q   <= ls_d;
			bor_q  <= bor_d;
			brownout_level_select_q <= brownout_level_select_d;
		end
	end

	assign PWM_PIN_TRISTATE      = tri_q;
	assign PWM_PIN_DRIVE         = drv_q;
	assign HIGH_SIDE_ACTIVE_HIGH = hs_q;
	assign LOW_SIDE_ACTIVE_HIGH  = ls_q;
	assign BROWNOUT_ENABLE       = bor_q;
	assign BROWNOUT_LEVEL_SELECT = brownout_level_select_q;
	assign INT_RESET             = ireset_q;

	// ahb-lite slave, zero wait states, read only
	logic        rd_take;
	logic [31:0] rdata_q, rdata_d;

	always_comb begin
		rd_take = HSEL && HREADY && HTRANS[1] && !HWRITE;
		rdata_d = 32'h0;
		if (rd_take) begin
			unique case (HADDR)
				`RPC_OFF_CFG:  rdata_d = {8'h00, word_d};
				`RPC_OFF_STAT: rdata_d = {30'h0, state_d == RPC_ST_RUN, ireset_d};
				default:       rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign HRDATA    = rdata_q;
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;

	// checks
	chk_unimpl_zero: assert property (@(posedge CLK) disable iff (RST)
		(word_q & ~`RPC_CFG_MASK) == 24'h0) else $error("unimplemented bits set");
	chk_pin_mode: assert property (@(posedge CLK) disable iff (RST)
		state_q == RPC_ST_WAIT |=> PWM_PIN_TRISTATE == $past(word_q[`RPC_BIT_PIN_MODE])
		&& PWM_PIN_DRIVE != PWM_PIN_TRISTATE) else $error("pin mode wrong");
	chk_hs_pol: assert property (@(posedge CLK) disable iff (RST)
		state_q != RPC_ST_LOAD |=> HIGH_SIDE_ACTIVE_HIGH == $past(word_q[`RPC_BIT_HS_POL]))
		else $error("high polarity wrong");
	chk_ls_pol: assert property (@(posedge CLK) disable iff (RST)
		state_q != RPC_ST_LOAD |=> LOW_SIDE_ACTIVE_HIGH == $past(word_q[`RPC_BIT_LS_POL]))
		else $error("low polarity wrong");
	chk_bor_en: assert property (@(posedge CLK) disable iff (RST)
		state_q != RPC_ST_LOAD |=> BROWNOUT_ENABLE == $past(word_q[`RPC_BIT_BOR_EN]))
		else $error("brownout enable wrong");
	chk_bor_lvl: assert property (@(posedge CLK) disable iff (RST)
		state_q != RPC_ST_LOAD
		|=> BROWNOUT_LEVEL_SELECT == $past(word_q[`RPC_BIT_BLVL_HI:`RPC_BIT_BLVL_LO]))
		else $error("brownout level wrong");
	sequence s_load_nodelay;
		state_q == RPC_ST_LOAD && NV_WORD[`RPC_BIT_PUD_HI:`RPC_BIT_PUD_LO] == 2'b00;
	endsequence
	chk_pud_off: assert property (@(posedge CLK) disable iff (RST)
		s_load_nodelay |-> ##2 !INT_RESET) else $error("reset not released");
	chk_pud_hold: assert property (@(posedge CLK) disable iff (RST)
		state_q == RPC_ST_LOAD && NV_WORD[`RPC_BIT_PUD_HI:`RPC_BIT_PUD_LO] != 2'b00
		|-> ##1 INT_RESET [*8])
		else $error("reset released early");
	chk_prog_read: assert property (@(posedge CLK) disable iff (RST)
		state_q == RPC_ST_LOAD
		|=> word_q[`RPC_BIT_PIN_MODE] == $past(NV_WORD[`RPC_BIT_PIN_MODE]))
		else $error("word bit inverted");
	chk_cfg_read: assert property (@(posedge CLK) disable iff (RST)
		HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR == `RPC_OFF_CFG
		&& state_q == RPC_ST_RUN |=> HRDATA == {8'h00, word_q})
		else $error("config read wrong");
	chk_pud_release: assert property (@(posedge CLK) disable iff (RST)
		state_q == RPC_ST_WAIT && tmr_done |=> !INT_RESET && state_q == RPC_ST_RUN)
		else $error("reset not released after delay");
endmodule // rpc_top

/* File: include/rpc_params.svh */
`ifndef RPC_PARAMS_SVH
`define RPC_PARAMS_SVH

// register byte addresses
`define RPC_OFF_CFG        12'h000
`define RPC_OFF_STAT       12'h004
`define RPC_OFF_CTRL       12'h008

// configuration word field positions
`define RPC_BIT_PIN_MODE   10
`define RPC_BIT_HS_POL     9
`define RPC_BIT_LS_POL     8
`define RPC_BIT_BOR_EN     7
`define RPC_BIT_BLVL_HI    5
`define RPC_BIT_BLVL_LO    4
`define RPC_BIT_PUD_HI     1
`define RPC_BIT_PUD_LO     0

// implemented bits (bit 15 pin-reset enable left out)
`define RPC_CFG_MASK       24'h0007B3
// erased word: every bit unprogrammed
`define RPC_CFG_ERASED     24'hFFFFFF

// power-up delays in ms, and the clock rate
`define RPC_CLK_HZ         50000000
`define RPC_PUD_MS_LONG    64
`define RPC_PUD_MS_MID     16
`define RPC_PUD_MS_SHORT   4
`define RPC_CYC_PER_MS     (`RPC_CLK_HZ / 1000)

`endif

/* File: include/rpc_pkg.sv */
package rpc_pkg;

	typedef struct packed {
		logic       pwm_pin_reset_mode;
		logic       high_side_polarity;
		logic       low_side_polarity;
		logic       brownout_enable;
		logic [1:0] brownout_level_select;
		logic [1:0] powerup_delay_select;
	} rpc_cfg_t;

	typedef enum logic [2:0] {
		RPC_ST_LOAD = 3'b001,
		RPC_ST_WAIT = 3'b010,
		RPC_ST_RUN  = 3'b100
	} rpc_state_t;

endpackage

/* File: rtl/rpc_pud_timer.sv */
`timescale 1ns/1ns
`include "rpc_params.svh"

// power-up delay counter: loaded once, counts down to zero
module rpc_pud_timer #(
	parameter int CNT_W = 32
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] load_val,
	output logic                  done
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = load_val;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - CNT_W'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign done = (cnt_q == '0) && !load;
endmodule // rpc_pud_timer

/* File: tb/rpc_top_bench.sv */
`timescale 1ns/1ns
`include "rpc_params.svh"

module rpc_top_bench;
	import rpc_pkg::*;

	localparam int MS = 4;

	logic        CLK = 1'b0;
	logic        RST = 1'b1;
	logic [23:0] NV_WORD = 24'hFFFFFF;
	logic        HSEL = 1'b0;
	logic [11:0] HADDR = 12'h000;
	logic [1:0]  HTRANS = 2'b00;
	logic        HWRITE = 1'b0;
	logic [2:0]  HSIZE = 3'h2;
	logic [31:0] HWDATA = 32'h0;
	logic [31:0] HRDATA;
	logic        HREADYOUT;
	logic        HRESP;
	logic        tri_st, drive, hi_ah, lo_ah, bor_en, int_rst;
	logic [1:0]  bor_lvl;
	int          errors = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          seed = 70320;
	int          n;
	int          lo;
	logic [23:0] w;
	logic [31:0] rd;
	logic [23:0] corner [4] = '{24'hFFFFFF, 24'h000000, 24'hFFFFDD, 24'hFFFBEE};

	rpc_top #(.MS_CYCLES(MS)) uut (
		.CLK(CLK), .RST(RST), .NV_WORD(NV_WORD), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.PWM_PIN_TRISTATE(tri_st), .PWM_PIN_DRIVE(drive), .HIGH_SIDE_ACTIVE_HIGH(hi_ah),
		.LOW_SIDE_ACTIVE_HIGH(lo_ah), .BROWNOUT_ENABLE(bor_en),
		.BROWNOUT_LEVEL_SELECT(bor_lvl), .INT_RESET(int_rst)
	);

	always #10 CLK = ~CLK;

	// cycle ceiling: a hang counts as a mismatch
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errors++;
			finish_test();
		end
	end

	function automatic int delay_ms(input logic [1:0] c);
		case (c)
			2'b11:   return `RPC_PUD_MS_LONG;
			2'b10:   return `RPC_PUD_MS_MID;
			2'b01:   return `RPC_PUD_MS_SHORT;
			default: return 0;
		endcase
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// single ahb-lite word transfer, waits on hready in both phases
	task automatic ahb(input logic [11:0] a, input logic wr, input logic [31:0] wd,
			output logic [31:0] r);
		HSEL   <= 1'b1;
		HADDR  <= a;
		HWRITE <= wr;
		HTRANS <= 2'b10;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'b00;
		HWDATA <= wd;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		r = HRDATA;
		chk("hresp", 32'h0, 32'(HRESP));
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		for (int i = 0; i < 12; i++) begin
			w = (i < 4) ? corner[i] : 24'($random(seed));
			@(posedge CLK);
			RST     <= 1'b1;
			NV_WORD <= w;
			repeat (3) @(posedge CLK);
			chk("tristate_in_reset", 32'h1, 32'(tri_st));
			chk("int_reset_in_reset", 32'h1, 32'(int_rst));
			RST <= 1'b0;
			// status read while the internal reset is still held
			ahb(`RPC_OFF_STAT, 1'b0, 32'h0, rd);
			chk("status_held", 32'h1, rd);
			n = 2;
			while (int_rst !== 1'b0 && n < 400) begin
				@(posedge CLK);
				n++;
			end
			lo = (w[1:0] == 2'b00) ? 1 : delay_ms(w[1:0]) * MS;
			chk("int_reset_delay", 32'h1, 32'(n >= lo && n <= lo + 4));
			// later changes of the stored word must be ignored
			NV_WORD <= ~w;
			@(posedge CLK);
			chk("pwm_pins", 32'({w[10], ~w[10]}), 32'({tri_st, drive}));
			chk("high_pol", 32'(w[9]), 32'(hi_ah));
			chk("low_pol", 32'(w[8]), 32'(lo_ah));
			chk("bor_enable", 32'(w[7]), 32'(bor_en));
			chk("bor_level", 32'(w[5:4]), 32'(bor_lvl));
			ahb(`RPC_OFF_CFG, 1'b0, 32'h0, rd);
			chk("cfg_word", {8'h00, w & `RPC_CFG_MASK}, rd);
			ahb(`RPC_OFF_CFG, 1'b1, ~rd, rd);
			ahb(`RPC_OFF_CFG, 1'b0, 32'h0, rd);
			chk("cfg_readonly", {8'h00, w & `RPC_CFG_MASK}, rd);
			ahb(`RPC_OFF_STAT, 1'b0, 32'h0, rd);
			chk("status_done", 32'h2, rd);
			ahb(`RPC_OFF_CTRL, 1'b0, 32'h0, rd);
			chk("reserved", 32'h0, rd);
			HSEL <= 1'b0;
		end
		finish_test();
	end
endmodule // rpc_top_bench
